// ===== jie_pkg.sv
package jie_pkg;

  // ==========================================================
  // quarter cycles and opcodes
  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } jie_q_t;

  typedef enum logic [2:0] {
    OP_IDLE = 3'b000,
    OP_NOP  = 3'b001,
    OP_JMP1 = 3'b010,
    OP_JMP2 = 3'b011,
    OP_INC  = 3'b100
  } jie_op_t;

  localparam logic [7:0]  JMP1_PFX   = 8'hEF;
  localparam logic [3:0]  JMP2_PFX   = 4'hF;
  localparam logic [5:0]  INC_PFX    = 6'h0A;
  localparam int          INC_D_BIT  = 9;
  localparam int          INC_A_BIT  = 8;
  localparam logic [7:0]  IDX_LIMIT  = 8'h5F;
  localparam logic [7:0]  ACC_SPLIT  = 8'h60;
  localparam logic [3:0]  ACC_HI     = 4'hF;
  localparam logic [20:0] PC_STEP    = 21'h000002;
  localparam logic [20:0] PC_RST     = 21'h000000;

  // ==========================================================
  // register map, byte addresses
  localparam logic [5:0] REG_CTRL  = 6'h00;
  localparam logic [5:0] REG_BANK  = 6'h04;
  localparam logic [5:0] REG_WACC  = 6'h08;
  localparam logic [5:0] REG_FLAGS = 6'h0C;
  localparam logic [5:0] REG_IDXL  = 6'h10;
  localparam logic [5:0] REG_IDXH  = 6'h14;
  localparam logic [5:0] REG_PCL   = 6'h18;
  localparam logic [5:0] REG_PCH   = 6'h1C;
  localparam logic [5:0] REG_PCU   = 6'h20;

  localparam int         CTRL_RUN  = 0;
  localparam int         CTRL_EXT  = 1;
  localparam logic [1:0] CTRL_RST  = 2'h0;
  localparam logic [3:0] BANK_RST  = 4'h0;
  localparam logic [7:0] WACC_RST  = 8'h00;
  localparam logic [11:0] IDX_RST  = 12'h000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } jie_flags_t;

  localparam jie_flags_t FLAGS_RST = 5'h00;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } jie_fr_req_t;

  localparam jie_fr_req_t FR_RST = 22'h000000;

endpackage

// ===== jie_inc_alu.sv
`timescale 1ns/1ps
module jie_inc_alu (
  // operand
  input  wire logic [7:0]         opnd,
  // sum and flags
  output logic [7:0]              sum,
  output jie_pkg::jie_flags_t     flags
);
  import jie_pkg::*;

  // ==========================================================
  // add one
  logic [8:0] wide;

  always_comb begin
    wide     = {1'b0, opnd} + 9'h001;
    sum      = wide[7:0];
    flags.c  = wide[8];
    flags.dc = (opnd[3:0] == 4'hF);
    flags.z  = (wide[7:0] == 8'h00);
    flags.n  = wide[7];
    flags.ov = (opnd == 8'h7F);
  end

endmodule // jie_inc_alu

// ===== jie_exec.sv
`timescale 1ns/1ps
module jie_exec (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // register port
  input  wire logic [5:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata_ff,
  // program fetch
  output logic [20:0]               prog_addr_ff,
  input  wire logic [15:0]          prog_data,
  // file register port
  output jie_pkg::jie_fr_req_t      fr_req_ff,
  input  wire logic [7:0]           fr_rdata
);
  import jie_pkg::*;

  // ==========================================================
  // state
  jie_q_t      q_ff,     nxt_q;
  jie_op_t     op_ff,    nxt_op;
  logic        pend_ff,  nxt_pend;
  logic [15:0] ir_ff,    nxt_ir;
  logic [7:0]  klo_ff,   nxt_klo;
  logic [20:0] pc_ff,    nxt_pc;
  logic [7:0]  res_ff,   nxt_res;
  jie_flags_t  rflg_ff,  nxt_rflg;
  logic [1:0]  ctrl_ff,  nxt_ctrl;
  logic [3:0]  bank_ff,  nxt_bank;
  logic [7:0]  wacc_ff,  nxt_wacc;
  jie_flags_t  flags_ff, nxt_flags;
  logic [11:0] idx_ff,   nxt_idx;
  logic [20:0] nxt_paddr;
  logic [7:0]  nxt_rdata;
  jie_fr_req_t nxt_fr;

  logic [7:0]  alu_sum;
  jie_flags_t  alu_flg;
  logic [7:0]  f_lit;
  logic [11:0] eff_addr;

  // ==========================================================
  // incrementer
  jie_inc_alu u_alu (
    .opnd  (fr_rdata),
    .sum   (alu_sum),
    .flags (alu_flg)
  );

  // ==========================================================
  // operand address
  always_comb begin
    f_lit = prog_data[7:0];
    if (prog_data[INC_A_BIT]) begin
      eff_addr = {bank_ff, f_lit};
    end else if (ctrl_ff[CTRL_EXT] && (f_lit <= IDX_LIMIT)) begin
      eff_addr = 12'(idx_ff + {4'h0, f_lit});
    end else if (f_lit < ACC_SPLIT) begin
      eff_addr = {4'h0, f_lit};
    end else begin
      eff_addr = {ACC_HI, f_lit};
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_q     = jie_q_t'(q_ff + 2'h1);
    nxt_op    = op_ff;
    nxt_pend  = pend_ff;
    nxt_ir    = ir_ff;
    nxt_klo   = klo_ff;
    nxt_pc    = pc_ff;
    nxt_res   = res_ff;
    nxt_rflg  = rflg_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_bank  = bank_ff;
    nxt_wacc  = wacc_ff;
    nxt_flags = flags_ff;
    nxt_idx   = idx_ff;
    nxt_paddr = prog_addr_ff;
    nxt_fr    = fr_req_ff;
    nxt_fr.rd = 1'b0;
    nxt_fr.wr = 1'b0;
    nxt_rdata = 8'h00;

    // software side
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL:  nxt_ctrl  = reg_wdata[1:0];
        REG_BANK:  nxt_bank  = reg_wdata[3:0];
        REG_WACC:  nxt_wacc  = reg_wdata;
        REG_FLAGS: nxt_flags = reg_wdata[4:0];
        REG_IDXL:  nxt_idx   = {idx_ff[11:8], reg_wdata};
        REG_IDXH:  nxt_idx   = {reg_wdata[3:0], idx_ff[7:0]};
        default:   nxt_ctrl  = ctrl_ff;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:  nxt_rdata = {6'h00, ctrl_ff};
        REG_BANK:  nxt_rdata = {4'h0, bank_ff};
        REG_WACC:  nxt_rdata = wacc_ff;
        REG_FLAGS: nxt_rdata = {3'h0, flags_ff};
        REG_IDXL:  nxt_rdata = idx_ff[7:0];
        REG_IDXH:  nxt_rdata = {4'h0, idx_ff[11:8]};
        REG_PCL:   nxt_rdata = pc_ff[7:0];
        REG_PCH:   nxt_rdata = pc_ff[15:8];
        REG_PCU:   nxt_rdata = {3'h0, pc_ff[20:16]};
        default:   nxt_rdata = 8'h00;
      endcase
    end

    // quarter-cycle sequencing, core wins over software
    unique case (q_ff)
      Q1: begin
        if (pend_ff) begin
          nxt_op   = OP_JMP2;
          nxt_pend = 1'b0;
        end else if (!ctrl_ff[CTRL_RUN]) begin
          nxt_op = OP_IDLE;
        end else begin
          nxt_ir = prog_data;
          if (prog_data[15:8] == JMP1_PFX) begin
            nxt_op    = OP_JMP1;
            nxt_paddr = 21'(pc_ff + PC_STEP);
          end else if (prog_data[15:10] == INC_PFX) begin
            nxt_op      = OP_INC;
            nxt_fr.rd   = 1'b1;
            nxt_fr.addr = eff_addr;
          end else begin
            nxt_op = OP_NOP;
          end
        end
      end
      Q2: begin
        if (op_ff == OP_JMP1) begin
          nxt_klo = ir_ff[7:0];
        end
      end
      Q3: begin
        if (op_ff == OP_INC) begin
          nxt_res      = alu_sum;
          nxt_rflg     = alu_flg;
          nxt_fr.wr    = ir_ff[INC_D_BIT];
          nxt_fr.wdata = alu_sum;
        end
      end
      Q4: begin
        unique case (op_ff)
          OP_JMP1: begin
            nxt_pc   = {prog_data[11:0], klo_ff, 1'b0};
            nxt_pend = 1'b1;
          end
          OP_INC: begin
            if (!ir_ff[INC_D_BIT]) begin
              nxt_wacc = res_ff;
            end
            nxt_flags = rflg_ff;
            nxt_pc    = 21'(pc_ff + PC_STEP);
          end
          OP_NOP: nxt_pc = 21'(pc_ff + PC_STEP);
          OP_JMP2, OP_IDLE: nxt_pc = pc_ff;
          default: nxt_pc = pc_ff;
        endcase
        nxt_paddr = nxt_pc;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q_ff         <= Q1;
      op_ff        <= OP_IDLE;
      pend_ff      <= 1'b0;
      ir_ff        <= 16'h0000;
      klo_ff       <= 8'h00;
      pc_ff        <= PC_RST;
      res_ff       <= 8'h00;
      rflg_ff      <= FLAGS_RST;
      ctrl_ff      <= CTRL_RST;
      bank_ff      <= BANK_RST;
      wacc_ff      <= WACC_RST;
      flags_ff     <= FLAGS_RST;
      idx_ff       <= IDX_RST;
      prog_addr_ff <= PC_RST;
      fr_req_ff    <= FR_RST;
      reg_rdata_ff <= 8'h00;
    end else begin
      q_ff         <= nxt_q;
      op_ff        <= nxt_op;
      pend_ff      <= nxt_pend;
      ir_ff        <= nxt_ir;
      klo_ff       <= nxt_klo;
      pc_ff        <= nxt_pc;
      res_ff       <= nxt_res;
      rflg_ff      <= nxt_rflg;
      ctrl_ff      <= nxt_ctrl;
      bank_ff      <= nxt_bank;
      wacc_ff      <= nxt_wacc;
      flags_ff     <= nxt_flags;
      idx_ff       <= nxt_idx;
      prog_addr_ff <= nxt_paddr;
      fr_req_ff    <= nxt_fr;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // checks
  sequence s_inc_read;
    fr_req_ff.rd ##1 !fr_req_ff.rd;
  endsequence

  sequence s_inc_write;
    (fr_req_ff.wr == ir_ff[INC_D_BIT]) && (fr_req_ff.wdata == 8'($past(fr_rdata) + 8'h01));
  endsequence

  a_jump_target: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q_ff == Q4 && op_ff == OP_JMP1)
      |=> (pc_ff == {$past(prog_data[11:0]), $past(klo_ff), 1'b0}) && !pc_ff[0])
    else $error("jump target not loaded into pc");

  a_jump_flags_kept: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ((op_ff == OP_JMP1 || op_ff == OP_JMP2) && !(reg_wr && reg_addr == REG_FLAGS))
      |=> $stable(flags_ff))
    else $error("jump changed status flags");

  a_jump_decode: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q_ff == Q1 && !pend_ff && ctrl_ff[CTRL_RUN] && prog_data[15:8] == JMP1_PFX)
      |=> (op_ff == OP_JMP1) ##1 (klo_ff == $past(ir_ff[7:0], 1)))
    else $error("jump first word not decoded");

  a_jump_two_cycles: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q_ff == Q2 && op_ff == OP_JMP1)
      |-> ##4 (op_ff == OP_JMP2) ##4 (op_ff != OP_JMP2))
    else $error("jump not two cycles");

  a_jump_second_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (op_ff == OP_JMP2) |-> !fr_req_ff.rd && !fr_req_ff.wr ##1 (pc_ff == $past(pc_ff)))
    else $error("jump second cycle not idle");

  a_inc_sequence: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q_ff == Q2 && op_ff == OP_INC) |-> s_inc_read ##1 s_inc_write)
    else $error("increment steps out of order");

  a_inc_to_acc: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q_ff == Q4 && op_ff == OP_INC && !ir_ff[INC_D_BIT]) |=> (wacc_ff == $past(res_ff)))
    else $error("increment result not in accumulator");

  a_inc_bank_addr: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q_ff == Q2 && op_ff == OP_INC && ir_ff[INC_A_BIT])
      |-> (fr_req_ff.addr == {$past(bank_ff), ir_ff[7:0]}))
    else $error("banked address wrong");

  a_inc_indexed: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q_ff == Q2 && op_ff == OP_INC && !ir_ff[INC_A_BIT] && $past(ctrl_ff[CTRL_EXT])
      && ir_ff[7:0] <= IDX_LIMIT)
      |-> (fr_req_ff.addr == 12'($past(idx_ff) + {4'h0, ir_ff[7:0]})))
    else $error("indexed address wrong");

  a_inc_wrap_flags: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q_ff == Q4 && op_ff == OP_INC && res_ff == 8'h00)
      |=> flags_ff.z && flags_ff.c && flags_ff.dc && !flags_ff.n)
    else $error("wrap flags wrong");

  a_inc_value: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q_ff == Q3 && op_ff == OP_INC) |=> (res_ff == 8'($past(fr_rdata) + 8'h01)))
    else $error("increment sum wrong");

endmodule // jie_exec

// ===== jump_and_increment_execute_tb_top.sv
`timescale 1ns/1ps
module jump_and_increment_execute_tb_top;
  import jie_pkg::*;

  // ==========================================================
  // clock, reset, ports
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [20:0] prog_addr;
  logic [15:0] prog_data;
  jie_fr_req_t fr_req;
  logic [7:0]  fr_rdata = 8'h00;
  logic [15:0] rom [0:1023];
  logic [7:0]  fmem [0:4095];
  int          cyc = 0;
  int          rd_cyc;
  int          n_mismatch = 0;
  int          n_compared = 0;
  logic [7:0]  rdv;

  always #2.5 ref_clk = ~ref_clk;

  jie_exec uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata),
    .prog_addr_ff(prog_addr), .prog_data(prog_data),
    .fr_req_ff(fr_req), .fr_rdata(fr_rdata)
  );

  // ==========================================================
  // program memory and file register model
  assign prog_data = rom[prog_addr[10:1]];

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    fr_rdata <= fr_req.rd ? fmem[fr_req.addr] : ~fr_rdata;
    if (fr_req.wr) begin
      fmem[fr_req.addr] <= fr_req.wdata;
    end
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_cyc(input int n);
    while (cyc != n) begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  // one increment: read request, destination write, flags
  task automatic chk_inc(input logic [11:0] a, input logic d, input logic [7:0] s,
                         input logic [7:0] fl);
    int k;
    k = 0;
    while (fr_req.rd !== 1'b1 && k < 40) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    rd_cyc = cyc;
    chk("fr_rd", 1, fr_req.rd);
    chk("fr_addr", a, fr_req.addr);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("fr_wr", d, fr_req.wr);
    if (d) chk("fr_wdata", s, fr_req.wdata);
    reg_read(REG_FLAGS, rdv);
    chk("flags", fl, rdv);
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset_values;
    logic [5:0] tbl [10] = '{REG_CTRL, REG_BANK, REG_WACC, REG_FLAGS, REG_IDXL,
                              REG_IDXH, REG_PCL, REG_PCH, REG_PCU, 6'h3C};
    foreach (tbl[i]) begin
      reg_read(tbl[i], rdv);
      chk("reset value", 0, rdv);
    end
    reg_write(REG_PCU, 8'hFF);
    reg_read(REG_PCU, rdv);
    chk("pcu read only", 0, rdv);
    $display("test_reset_values done");
  endtask

  task automatic test_increments;
    reg_write(REG_BANK, 8'h02);
    reg_write(REG_IDXL, 8'h23);
    reg_write(REG_IDXH, 8'h01);
    reg_write(REG_CTRL, 8'h03);
    chk_inc(12'h220, 1'b1, 8'h00, 8'h07);
    chk_inc(12'hF70, 1'b0, 8'h80, 8'h1A);
    chk_inc(12'h133, 1'b1, 8'h50, 8'h02);
    $display("test_increments done");
  endtask

  task automatic test_jump;
    int c0;
    c0 = rd_cyc;
    reg_read(REG_FLAGS, rdv);
    chk("flags in jump", 8'h02, rdv);
    chk("word2 fetch", 21'h000008, prog_addr);
    wait_cyc(c0 + 6);
    chk("pc before q4", 21'h000008, prog_addr);
    wait_cyc(c0 + 7);
    chk("jump target", 21'h1002AA, prog_addr);
    chk_inc(12'hF61, 1'b1, 8'h00, 8'h07);
    chk("jump cycles", 12, rd_cyc - c0);
    $display("test_jump done");
  endtask

  // extended set off: low access bank half, no indexing
  task automatic test_access_bank;
    reg_write(REG_CTRL, 8'h01);
    chk_inc(12'h030, 1'b1, 8'h10, 8'h02);
    $display("test_access_bank done");
  endtask

  task automatic test_final_state;
    reg_write(REG_CTRL, 8'h00);
    repeat (8) @(posedge ref_clk);
    reg_read(REG_WACC, rdv);
    chk("wacc", 8'h80, rdv);
    reg_read(REG_PCU, rdv);
    chk("pcu", 8'h10, rdv);
    chk("mem 220", 8'h00, fmem[12'h220]);
    chk("mem f70", 8'h7F, fmem[12'hF70]);
    chk("mem 133", 8'h50, fmem[12'h133]);
    chk("mem f61", 8'h00, fmem[12'hF61]);
    chk("mem 030", 8'h10, fmem[12'h030]);
    $display("test_final_state done");
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    foreach (rom[i]) rom[i] = 16'h0000;
    foreach (fmem[i]) fmem[i] = 8'h00;
    rom[0] = 16'h2B20;
    rom[1] = 16'h2870;
    rom[2] = 16'h2A10;
    rom[3] = 16'hEF55;
    rom[4] = 16'hF801;
    rom[10'h155] = 16'h2A61;
    rom[10'h157] = 16'h2A30;
    fmem[12'h220] = 8'hFF;
    fmem[12'hF70] = 8'h7F;
    fmem[12'h133] = 8'h4F;
    fmem[12'hF61] = 8'hFF;
    fmem[12'h030] = 8'h0F;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_reset_values();
    test_increments();
    test_jump();
    test_access_bank();
    test_final_state();
    wrap_up();
  end

endmodule // jump_and_increment_execute_tb_top
